// [rtl/mrd_decoder.sv]
`timescale 1ns/100ps

// Behaviour
// - accept reads 3,4,23 and writes 6,16,22,23
// - reads 0x0000-0x03e7 return program input image
// - reads 0x03e8-0x07cf return program output image
// - combined request on output image: read only
// - reads 0x07d0-0x0fff answer exception 0x02
// - info window; undefined address reads give 0x02
// - combined write in window only to writable
// - 0x3000 upward maps linearly onto flag area
// - usable flag size is configurable
// - writes 0x0000-0x03e7 store into input image
// - writes 0x03e8-0x0fff store nothing, answer 0x02 except combined on output image
// - masked write refused in info window
// - window writes to undefined address give 0x02
module mrd_decoder
    import mrd_pkg::*;
#(
    parameter logic [16:0] FLAG_WORDS = FLAG_DEFAULT_WORDS
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // request
    input wire logic req_valid_i,
    input wire mrd_req_t req_i,
    input wire logic [16:0] flag_words_i,
    // decoded answer
    output logic resp_valid_o,
    output mrd_resp_t resp_o,
    output mrd_region_t rd_region_o,
    output logic [15:0] rd_offset_o,
    output mrd_region_t wr_region_o,
    output logic [15:0] wr_offset_o
);

    logic is_read;
    logic is_write;
    logic known_fc;
    logic rd_legal;
    logic wr_legal;
    logic [16:0] flag_words;
    mrd_region_t rd_region;
    mrd_region_t wr_region;
    logic [15:0] rd_first;
    logic [7:0] rd_count;
    logic [15:0] wr_first;
    logic [7:0] wr_count;
    mrd_resp_t resp_nxt;

    // ------------------------------------------------------------
    // function decode
    // ------------------------------------------------------------
    always_comb begin
        is_read = 1'b0;
        is_write = 1'b0;
        known_fc = 1'b1;
        case (req_i.func)
            FC_READ_HOLD, FC_READ_INPUT: is_read = 1'b1;
            FC_WRITE_SINGLE, FC_WRITE_MULTI, FC_MASK_WRITE: is_write = 1'b1;
            FC_READ_WRITE: begin
                is_read = 1'b1;
                is_write = 1'b1;
            end
            default: known_fc = 1'b0;
        endcase
    end

    // single-word services always span exactly one register
    always_comb begin
        rd_first = req_i.rd_addr;
        rd_count = req_i.rd_count;
        wr_first = (req_i.func == FC_READ_WRITE) ? req_i.wr_addr : req_i.rd_addr;
        wr_count = req_i.wr_count;
        if (req_i.func == FC_WRITE_SINGLE || req_i.func == FC_MASK_WRITE) begin
            wr_first = req_i.rd_addr;
            wr_count = 8'h01;
        end
        if (req_i.func == FC_WRITE_MULTI) begin
            wr_first = req_i.rd_addr;
            wr_count = req_i.rd_count;
        end
    end

    // a zero size falls back to the build default; cap at the maximum
    always_comb begin
        flag_words = (flag_words_i == 17'h00000) ? FLAG_WORDS : flag_words_i;
        if (flag_words > 17'(FLAG_MAX_WORDS)) begin
            flag_words = 17'(FLAG_MAX_WORDS);
        end
    end

    // ------------------------------------------------------------
    // region checks
    // ------------------------------------------------------------
    mrd_region_check u_rd_check (
        .first_i(rd_first),
        .count_i(rd_count),
        .is_write_i(1'b0),
        .is_mask_i(1'b0),
        .flag_words_i(flag_words),
        .legal_o(rd_legal),
        .region_o(rd_region)
    );

    mrd_region_check u_wr_check (
        .first_i(wr_first),
        .count_i(wr_count),
        .is_write_i(1'b1),
        .is_mask_i(req_i.func == FC_MASK_WRITE),
        .flag_words_i(flag_words),
        .legal_o(wr_legal),
        .region_o(wr_region)
    );

    // ------------------------------------------------------------
    // answer
    // ------------------------------------------------------------
    always_comb begin
        resp_nxt.rd_en = 1'b0;
        resp_nxt.wr_en = 1'b0;
        resp_nxt.exc = EXC_NONE;
        if (!known_fc) begin
            resp_nxt.exc = EXC_ILLEGAL_FUNCTION;
        end else if (is_read && is_write) begin
            // output image refuses the write half but still serves the read
            if (!rd_legal) begin
                resp_nxt.exc = EXC_ILLEGAL_ADDRESS;
            end else if (rd_region == MRD_REG_OUT_IMG || wr_region == MRD_REG_OUT_IMG) begin
                resp_nxt.rd_en = 1'b1;
            end else if (!wr_legal) begin
                resp_nxt.exc = EXC_ILLEGAL_ADDRESS;
            end else begin
                resp_nxt.rd_en = 1'b1;
                resp_nxt.wr_en = 1'b1;
            end
        end else if (is_read) begin
            resp_nxt.rd_en = rd_legal;
            resp_nxt.exc = rd_legal ? EXC_NONE : EXC_ILLEGAL_ADDRESS;
        end else begin
            resp_nxt.wr_en = wr_legal;
            resp_nxt.exc = wr_legal ? EXC_NONE : EXC_ILLEGAL_ADDRESS;
        end
    end

    // offsets are relative to each region's first word; the gap uses base 0
    function automatic logic [15:0] region_base(input mrd_region_t r);
        logic [15:0] b;
        b = 16'h0000;
        case (r)
            MRD_REG_IN_IMG: b = IN_IMG_FIRST;
            MRD_REG_OUT_IMG: b = OUT_IMG_FIRST;
            MRD_REG_INFO: b = INFO_FIRST;
            MRD_REG_FLAG: b = FLAG_FIRST;
            default: b = 16'h0000;
        endcase
        return b;
    endfunction : region_base

    // ------------------------------------------------------------
    // registered outputs; one cycle latency
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            resp_valid_o <= 1'b0;
        end else if (ce_i) begin
            resp_valid_o <= req_valid_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            resp_o <= '0;
            rd_region_o <= MRD_REG_GAP;
            rd_offset_o <= 16'h0000;
            wr_region_o <= MRD_REG_GAP;
            wr_offset_o <= 16'h0000;
        end else if (ce_i && req_valid_i) begin
            resp_o <= resp_nxt;
            rd_region_o <= rd_region;
            rd_offset_o <= rd_first - region_base(rd_region);
            wr_region_o <= wr_region;
            wr_offset_o <= wr_first - region_base(wr_region);
        end
    end

    // flag area is shared with the program unarbitrated

endmodule : mrd_decoder

// [include/mrd_pkg.sv]
package mrd_pkg;

    // ------------------------------------------------------------
    // function codes
    // ------------------------------------------------------------
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [7:0] FC_READ_INPUT = 8'h04;
    localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
    localparam logic [7:0] FC_MASK_WRITE = 8'h16;
    localparam logic [7:0] FC_READ_WRITE = 8'h17;

    // ------------------------------------------------------------
    // exception codes
    // ------------------------------------------------------------
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [15:0] IN_IMG_FIRST = 16'h0000;
    localparam logic [15:0] IN_IMG_LAST = 16'h03e7;
    localparam logic [15:0] OUT_IMG_FIRST = 16'h03e8;
    localparam logic [15:0] OUT_IMG_LAST = 16'h07cf;
    localparam logic [15:0] GAP_FIRST = 16'h07d0;
    localparam logic [15:0] GAP_LAST = 16'h0fff;
    localparam logic [15:0] INFO_FIRST = 16'h1000;
    localparam logic [15:0] INFO_LAST = 16'h2fff;
    localparam logic [15:0] FLAG_FIRST = 16'h3000;
    localparam int IMG_WORDS = 1000;
    localparam int FLAG_MAX_WORDS = 53248;
    localparam logic [16:0] FLAG_DEFAULT_WORDS = 17'h03000;

    // ------------------------------------------------------------
    // information window table
    // ------------------------------------------------------------
    localparam int INFO_ENTRIES = 31;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MRD_REG_IN_IMG,
        MRD_REG_OUT_IMG,
        MRD_REG_GAP,
        MRD_REG_INFO,
        MRD_REG_FLAG
    } mrd_region_t;

    typedef struct packed {
        logic [7:0] func;
        logic [15:0] rd_addr;
        logic [7:0] rd_count;
        logic [15:0] wr_addr;
        logic [7:0] wr_count;
    } mrd_req_t;

    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [7:0] exc;
    } mrd_resp_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [1:0] access;
    } mrd_info_t;

    localparam logic [1:0] ACC_RO = 2'h1;
    localparam logic [1:0] ACC_WO = 2'h2;
    localparam logic [1:0] ACC_RW = 2'h3;

endpackage : mrd_pkg

// [rtl/mrd_region_check.sv]
`timescale 1ns/100ps

// classifies an address span [first, first+count-1] for one direction
module mrd_region_check
    import mrd_pkg::*;
(
    // span
    input wire logic [15:0] first_i,
    input wire logic [7:0] count_i,
    input wire logic is_write_i,
    input wire logic is_mask_i,
    // flag area size
    input wire logic [16:0] flag_words_i,
    // result
    output logic legal_o,
    output mrd_region_t region_o
);

    logic [16:0] last;
    logic info_ok;

    // ------------------------------------------------------------
    // window table
    // ------------------------------------------------------------
    localparam mrd_info_t INFO_TABLE [INFO_ENTRIES] = '{
        '{16'h1022, ACC_RO}, '{16'h1023, ACC_RO}, '{16'h1024, ACC_RO},
        '{16'h1025, ACC_RO}, '{16'h1028, ACC_RO}, '{16'h102a, ACC_RO},
        '{16'h1030, ACC_RW}, '{16'h1031, ACC_RO}, '{16'h1032, ACC_RO},
        '{16'h1033, ACC_RO}, '{16'h1037, ACC_RW}, '{16'h1040, ACC_RO},
        '{16'h1100, ACC_WO}, '{16'h1101, ACC_RO}, '{16'h1102, ACC_RW},
        '{16'h1103, ACC_RW}, '{16'h1104, ACC_RW}, '{16'h2000, ACC_RO},
        '{16'h2001, ACC_RO}, '{16'h2002, ACC_RO}, '{16'h2003, ACC_RO},
        '{16'h2004, ACC_RO}, '{16'h2005, ACC_RO}, '{16'h2006, ACC_RO},
        '{16'h2007, ACC_RO}, '{16'h2008, ACC_RO}, '{16'h2010, ACC_RO},
        '{16'h2011, ACC_RO}, '{16'h2012, ACC_RO}, '{16'h2013, ACC_RO},
        '{16'h2014, ACC_RO}
    };

    // every word of the span must name a register of the right access
    function automatic logic word_ok(input logic [15:0] a, input logic wr);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < INFO_ENTRIES; i++) begin
            if (INFO_TABLE[i].addr == a) begin
                hit = wr ? INFO_TABLE[i].access[1] : INFO_TABLE[i].access[0];
            end
        end
        return hit;
    endfunction : word_ok

    always_comb begin
        last = {1'b0, first_i} + {9'h000, count_i} - 17'h00001;
        info_ok = 1'b1;
        for (int k = 0; k < 256; k++) begin
            if (k < int'(count_i)) begin
                info_ok = info_ok & word_ok(first_i + 16'(k), is_write_i);
            end
        end
        region_o = MRD_REG_GAP;
        legal_o = 1'b0;
        if (count_i == 8'h00 || last > 17'h0ffff) begin
            legal_o = 1'b0;
        end else if (last <= {1'b0, IN_IMG_LAST}) begin
            region_o = MRD_REG_IN_IMG;
            legal_o = 1'b1;
        end else if (first_i >= OUT_IMG_FIRST && last <= {1'b0, OUT_IMG_LAST}) begin
            region_o = MRD_REG_OUT_IMG;
            legal_o = !is_write_i;
        end else if (first_i >= INFO_FIRST && last <= {1'b0, INFO_LAST}) begin
            region_o = MRD_REG_INFO;
            legal_o = info_ok && !is_mask_i;
        end else if (first_i >= FLAG_FIRST) begin
            region_o = MRD_REG_FLAG;
            legal_o = (last - {1'b0, FLAG_FIRST}) < flag_words_i;
        end
        // spans straddling two regions or touching the gap stay illegal
    end

endmodule : mrd_region_check

// [test/mrd_chk.sv]
`timescale 1ns/100ps

module mrd_chk
    import mrd_pkg::*;
#(
    parameter logic [16:0] FLAG_WORDS = FLAG_DEFAULT_WORDS
)
(
    // watched ports
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire mrd_req_t req_i,
    input wire logic [16:0] flag_words_i,
    input wire logic resp_valid_o,
    input wire mrd_resp_t resp_o,
    input wire mrd_region_t rd_region_o,
    input wire logic [15:0] rd_offset_o,
    input wire mrd_region_t wr_region_o,
    input wire logic [15:0] wr_offset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic tk;
    logic fl;
    logic [15:0] ra;
    logic [7:0] fc;
    assign tk = req_valid_i && ce_i;
    assign ra = req_i.rd_addr;
    assign fc = req_i.func;
    // default flag size only; capped sizes are left to the bench
    assign fl = tk && flag_words_i == 17'h00000 && ra >= FLAG_FIRST;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_resp_next: assert property (tk |=> resp_valid_o)
        else $error("no response after request");
    a_idle_hold: assert property (ce_i && !req_valid_i |=> !resp_valid_o && $stable(resp_o))
        else $error("outputs moved without request");
    a_ce_freeze: assert property (!ce_i |=> $stable(resp_valid_o) && $stable(rd_offset_o))
        else $error("state moved with ce low");
    a_gap_read_bad: assert property (
        tk && fc == FC_READ_HOLD && ra >= GAP_FIRST && ra <= GAP_LAST
        |=> resp_o.exc == EXC_ILLEGAL_ADDRESS && !resp_o.rd_en)
        else $error("gap read not refused");
    a_out_write_bad: assert property (
        tk && (fc == FC_WRITE_SINGLE || fc == FC_WRITE_MULTI)
        && ra >= OUT_IMG_FIRST && ra <= GAP_LAST
        |=> resp_o.exc == EXC_ILLEGAL_ADDRESS && !resp_o.wr_en)
        else $error("write to inhibited area not refused");
    a_mask_info_bad: assert property (
        tk && fc == FC_MASK_WRITE && ra >= INFO_FIRST && ra <= INFO_LAST
        |=> resp_o.exc == EXC_ILLEGAL_ADDRESS && !resp_o.wr_en)
        else $error("masked write in window not refused");
    a_combined_out: assert property (
        tk && fc == FC_READ_WRITE && ra == OUT_IMG_FIRST
        && req_i.rd_count == 8'h01 && req_i.wr_addr == OUT_IMG_FIRST && req_i.wr_count == 8'h01
        |=> resp_o.rd_en && !resp_o.wr_en)
        else $error("combined write applied to output image");
    a_out_offset: assert property (
        tk && fc == FC_READ_INPUT && ra >= OUT_IMG_FIRST
        && ra <= OUT_IMG_LAST && req_i.rd_count == 8'h01
        |=> rd_region_o == MRD_REG_OUT_IMG && rd_offset_o == $past(ra) - OUT_IMG_FIRST)
        else $error("output image offset wrong");
    a_flag_linear: assert property (
        fl && fc == FC_READ_HOLD && req_i.rd_count == 8'h01
        && {1'b0, ra - FLAG_FIRST} < FLAG_WORDS
        |=> resp_o.rd_en && rd_offset_o == $past(ra) - FLAG_FIRST)
        else $error("flag read not linear");
    a_flag_limit: assert property (
        fl && fc == FC_READ_HOLD && {1'b0, ra - FLAG_FIRST} >= FLAG_WORDS
        |=> resp_o.exc == EXC_ILLEGAL_ADDRESS)
        else $error("flag read beyond size accepted");
    c_refused: cover property (resp_valid_o && resp_o.exc == EXC_ILLEGAL_ADDRESS);
    c_read_only: cover property (resp_valid_o && resp_o.rd_en && !resp_o.wr_en);
    c_write: cover property (resp_valid_o && resp_o.wr_en);
endmodule : mrd_chk

bind mrd_decoder mrd_chk #(.FLAG_WORDS(FLAG_WORDS)) mrd_chk_inst (.clk_i(clk_i),
    .resetn_i(resetn_i), .ce_i(ce_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .flag_words_i(flag_words_i), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
    .rd_region_o(rd_region_o), .rd_offset_o(rd_offset_o), .wr_region_o(wr_region_o),
    .wr_offset_o(wr_offset_o));

// [test/mrd_master.sv]
`timescale 1ns/100ps

module mrd_master
    import mrd_pkg::*;
(
    // request side
    input wire logic clk_i,
    output logic req_valid_o,
    output mrd_req_t req_o
);
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    // no retry or locking: flag words shared with the program may be torn
    task automatic send(input mrd_req_t r);
        @(posedge clk_i);
        #1;
        req_valid_o = 1'b1;
        req_o = r;
        @(posedge clk_i);
        #1;
        req_valid_o = 1'b0;
        req_o = ~r;
    endtask : send
endmodule : mrd_master

// [test/tb.sv]
`timescale 1ns/100ps

module tb;
    import mrd_pkg::*;
    localparam logic [16:0] FW = 17'h00020;
    localparam logic [9:0] RD = 10'h200;
    localparam logic [9:0] WR = 10'h100;
    localparam logic [9:0] RW = 10'h300;
    localparam logic [9:0] BAD = 10'h002;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic [16:0] flag_words_i = 17'h00000;
    logic req_valid;
    mrd_req_t req;
    logic resp_valid_o;
    mrd_resp_t resp_o;
    mrd_region_t rd_region_o;
    mrd_region_t wr_region_o;
    logic [15:0] rd_offset_o;
    logic [15:0] wr_offset_o;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #50 clk_i = ~clk_i;
    mrd_master mrd_master_inst (.clk_i(clk_i), .req_valid_o(req_valid), .req_o(req));
    mrd_decoder #(.FLAG_WORDS(FW)) mrd_decoder_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .ce_i(ce_i), .req_valid_i(req_valid), .req_i(req), .flag_words_i(flag_words_i),
        .resp_valid_o(resp_valid_o), .resp_o(resp_o), .rd_region_o(rd_region_o),
        .rd_offset_o(rd_offset_o), .wr_region_o(wr_region_o), .wr_offset_o(wr_offset_o));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic txn(input logic [7:0] f, input logic [15:0] ra, input logic [7:0] rc,
                       input logic [15:0] wa, input logic [7:0] wc, input logic [9:0] exp);
        mrd_master_inst.send('{f, ra, rc, wa, wc});
        check("resp_valid", resp_valid_o, 1'b1);
        check("resp", resp_o, exp);
    endtask : txn
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_codes();
        txn(FC_READ_HOLD, 16'h0000, 8'h01, 16'h0000, 8'h00, RD);
        txn(FC_READ_INPUT, 16'h03e7, 8'h01, 16'h0000, 8'h00, RD);
        check("rd_offset", rd_offset_o, 16'h03e7);
        txn(FC_WRITE_SINGLE, 16'h0000, 8'h01, 16'h0000, 8'h00, WR);
        txn(FC_WRITE_MULTI, 16'h0000, 8'hff, 16'h0000, 8'h00, WR);
        txn(FC_MASK_WRITE, 16'h03e7, 8'h01, 16'h0000, 8'h00, WR);
        check("wr_offset", wr_offset_o, 16'h03e7);
        txn(FC_READ_WRITE, 16'h0000, 8'h01, 16'h0001, 8'h01, RW);
        txn(FC_WRITE_MULTI, 16'h03e7, 8'h02, 16'h0000, 8'h00, BAD);
        txn(FC_READ_HOLD, 16'h0000, 8'h00, 16'h0000, 8'h00, BAD);
        txn(8'h05, 16'h0000, 8'h01, 16'h0000, 8'h00, 10'h001);
        $display("test codes done");
    endtask : t_codes
    task automatic t_out_gap();
        txn(FC_READ_INPUT, 16'h07cf, 8'h01, 16'h0000, 8'h00, RD);
        check("rd_region", rd_region_o, MRD_REG_OUT_IMG);
        txn(FC_READ_WRITE, 16'h03e8, 8'h01, 16'h03e8, 8'h01, RD);
        txn(FC_WRITE_SINGLE, 16'h03e8, 8'h01, 16'h0000, 8'h00, BAD);
        txn(FC_WRITE_MULTI, 16'h0fff, 8'h01, 16'h0000, 8'h00, BAD);
        txn(FC_READ_HOLD, 16'h07d0, 8'h01, 16'h0000, 8'h00, BAD);
        txn(FC_READ_INPUT, 16'h0fff, 8'h01, 16'h0000, 8'h00, BAD);
        txn(FC_READ_HOLD, 16'h07cf, 8'h02, 16'h0000, 8'h00, BAD);
        $display("test output image and gap done");
    endtask : t_out_gap
    task automatic t_info();
        txn(FC_READ_HOLD, 16'h1022, 8'h01, 16'h0000, 8'h00, RD);
        check("rd_region", rd_region_o, MRD_REG_INFO);
        txn(FC_READ_HOLD, 16'h1026, 8'h01, 16'h0000, 8'h00, BAD);
        txn(FC_READ_INPUT, 16'h1031, 8'h03, 16'h0000, 8'h00, RD);
        txn(FC_WRITE_SINGLE, 16'h1030, 8'h01, 16'h0000, 8'h00, WR);
        txn(FC_MASK_WRITE, 16'h1030, 8'h01, 16'h0000, 8'h00, BAD);
        txn(FC_WRITE_MULTI, 16'h2015, 8'h01, 16'h0000, 8'h00, BAD);
        txn(FC_WRITE_SINGLE, 16'h1022, 8'h01, 16'h0000, 8'h00, BAD);
        txn(FC_READ_WRITE, 16'h2000, 8'h01, 16'h1037, 8'h01, RW);
        check("wr_region", wr_region_o, MRD_REG_INFO);
        check("wr_offset", wr_offset_o, 16'h0037);
        txn(FC_READ_WRITE, 16'h2000, 8'h01, 16'h2001, 8'h01, BAD);
        $display("test info window done");
    endtask : t_info
    task automatic t_flag();
        txn(FC_READ_HOLD, 16'h3000, 8'h01, 16'h0000, 8'h00, RD);
        check("rd_region", rd_region_o, MRD_REG_FLAG);
        txn(FC_WRITE_MULTI, 16'h301f, 8'h01, 16'h0000, 8'h00, WR);
        txn(FC_READ_HOLD, 16'h3020, 8'h01, 16'h0000, 8'h00, BAD);
        txn(FC_READ_HOLD, 16'h301f, 8'h02, 16'h0000, 8'h00, BAD);
        flag_words_i = 17'h00040;
        txn(FC_READ_HOLD, 16'h3020, 8'h01, 16'h0000, 8'h00, RD);
        flag_words_i = 17'h1ffff;
        txn(FC_READ_HOLD, 16'hffff, 8'h01, 16'h0000, 8'h00, RD);
        check("rd_offset", rd_offset_o, 16'hcfff);
        flag_words_i = 17'h00000;
        $display("test flag area done");
    endtask : t_flag
    task automatic t_ce_reset();
        // let the last answer pulse drop first: ce low would freeze it high
        @(posedge clk_i);
        #1;
        ce_i = 1'b0;
        mrd_master_inst.send('{FC_READ_HOLD, 16'h0001, 8'h01, 16'h0000, 8'h00});
        ce_i = 1'b1;
        check("resp_valid", resp_valid_o, 1'b0);
        check("rd_offset", rd_offset_o, 16'hcfff);
        resetn_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        check("rd_region", rd_region_o, MRD_REG_GAP);
        txn(FC_READ_HOLD, 16'h0002, 8'h01, 16'h0000, 8'h00, RD);
        $display("test clock enable and reset done");
    endtask : t_ce_reset
    // hang guard: whole sequence needs about 70 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        t_codes();
        t_out_gap();
        t_info();
        t_flag();
        t_ce_reset();
        results();
    end
endmodule : tb
